// >>> sirq_pkg.sv
// package: register offsets, field positions, reset values for sirq block
package sirq_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;
    // register offsets (word addresses on the host bus)
    localparam logic [4:0] OFF_FLAG_CC = 5'h1b;
    localparam logic [4:0] OFF_SELFTEST = 5'h1c;
    localparam logic [4:0] OFF_IRQ_EN2 = 5'h1d;
    localparam logic [4:0] OFF_IRQ_ST2 = 5'h1e;
    // reset values
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [15:0] RST_EN2 = 16'h0000;
    localparam logic [15:0] RST_ST2 = 16'h0000;
    localparam logic [15:0] RST_SELFTEST = 16'h0000;
    // self-test status field positions
    localparam int unsigned ST_PROT_DONE = 15;
    localparam int unsigned ST_PROT_BUSY = 14;
    localparam int unsigned ST_PROT_PASS = 13;
    localparam int unsigned ST_PROT_ABORT = 12;
    localparam int unsigned ST_PROT_DONE_OR_BUSY = 11;
    localparam int unsigned ST_RAM_DONE = 7;
    localparam int unsigned ST_RAM_BUSY = 6;
    localparam int unsigned ST_RAM_PASS = 5;
    // second status register field positions
    localparam int unsigned B_SUMMARY = 15;
    localparam int unsigned B_PARITY = 14;
    localparam int unsigned B_ILLEGAL_CMD_OR_MSG_STORED = 13;
    localparam int unsigned B_ROLLOVER = 12;
    localparam int unsigned B_STACK = 11;
    localparam int unsigned B_OPCODE = 10;
    localparam int unsigned B_RT_STK = 9;
    localparam int unsigned B_RT_CIRC = 8;
    localparam int unsigned B_MT_STK = 7;
    localparam int unsigned B_MT_DATA = 6;
    localparam int unsigned B_UIRQ_LO = 2;
    localparam int unsigned B_SELFTEST = 1;
    localparam int unsigned B_FIRST = 0;
    // event bits that can interrupt (14..1)
    localparam logic [15:0] EVENT_MASK = 16'h7ffe;
    // operating modes
    typedef enum logic [1:0] {
        SIRQ_MODE_SEQ = 2'b00,
        SIRQ_MODE_RT = 2'b01,
        SIRQ_MODE_MON = 2'b10
    } sirq_mode_e;
endpackage

// >>> sirq_flags.sv
// general purpose flag set/clear register
module sirq_flags (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    output logic [7:0] flags
);
    typedef struct packed {
        logic [7:0] flags;
    } sirq_flags_s;

    sirq_flags_s st_q; // registered state
    sirq_flags_s st_d; // next state

    // upper byte clears, lower byte sets; set wins on the same bit
    always_comb begin
        st_d = st_q;
        if (wr_stb) begin
            st_d.flags = st_q.flags & ~wr_data[15:8];
            st_d.flags = st_d.flags | wr_data[7:0];
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.flags <= sirq_pkg::RST_FLAGS[7:0];
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;
endmodule // sirq_flags

// >>> sirq_top.sv
// secondary interrupt, self-test status and flag register block
module sirq_top (
    input wire logic clk,
    input wire logic rst_n,
    // host register port, same clock as the device
    input wire logic [4:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_rdata_valid,
    // condition codes for read-back at the flag address
    input wire logic [15:0] cond_code,
    // current operating mode
    input wire logic [1:0] op_mode,
    // event pulses from the device logic
    input wire logic sequencer_instr_parity_err,
    input wire logic illegal_cmd_or_msg_stored,
    input wire logic gp_queue_rollover,
    input wire logic isq_queue_rollover,
    input wire logic call_stack_error,
    input wire logic illegal_opcode_fetch,
    input wire logic terminal_cmd_stack_half,
    input wire logic terminal_circ_buffer_half,
    input wire logic monitor_cmd_stack_half,
    input wire logic monitor_data_stack_half,
    input wire logic sequencer_user_irq_stb,
    input wire logic [15:0] sequencer_user_irq,
    // first interrupt status register contents
    input wire logic [15:0] first_status,
    // self-test status inputs
    input wire logic prot_test_done,
    input wire logic prot_test_busy,
    input wire logic prot_test_pass,
    input wire logic prot_test_abort,
    input wire logic ram_test_done,
    input wire logic ram_test_busy,
    input wire logic ram_test_pass,
    input wire logic self_test_clear,
    // general purpose flags and interrupt request
    output logic [7:0] general_flags,
    output logic irq_req
);
    typedef struct packed {
        logic [15:0] en2;
        logic [15:0] st2;
        logic [15:0] selftest;
        logic [15:0] rdata;
        logic rvalid;
        logic irq;
        logic done; // previous completion level for edge detect
        logic [7:0] gflags; // flags copy that drives the output
    } sirq_top_s;

    sirq_top_s st_q; // registered state
    sirq_top_s st_d; // next state

    logic flag_wr; // host write to the flag address
    logic [7:0] flags_w; // flag register contents
    logic self_test_done; // protocol or memory test finished this cycle
    logic queue_rollover; // mode-selected rollover event
    logic [15:0] ev; // event bits of this cycle

    // writes at the shared address go to the flag register
    assign flag_wr = host_wr && (host_addr == sirq_pkg::OFF_FLAG_CC);

    // flag set/clear register
    sirq_flags u_flags (
        .clk(clk),
        .rst_n(rst_n),
        .wr_stb(flag_wr),
        .wr_data(host_wdata),
        .flags(flags_w)
    );

    // completion edge, used for the self-test event bit
    assign self_test_done = (prot_test_done | ram_test_done) & ~st_q.done;

    // rollover source depends on the mode
    always_comb begin
        case (op_mode)
            sirq_pkg::SIRQ_MODE_SEQ: queue_rollover = gp_queue_rollover;
            sirq_pkg::SIRQ_MODE_RT: queue_rollover = isq_queue_rollover;
            sirq_pkg::SIRQ_MODE_MON: queue_rollover = isq_queue_rollover;
            default: queue_rollover = 1'b0;
        endcase
    end

    // gather event bits into their status positions
    always_comb begin
        ev = 16'h0000;
        ev[sirq_pkg::B_PARITY] = sequencer_instr_parity_err;
        ev[sirq_pkg::B_ILLEGAL_CMD_OR_MSG_STORED] = illegal_cmd_or_msg_stored;
        ev[sirq_pkg::B_ROLLOVER] = queue_rollover;
        // stack errors only count in sequencer mode
        ev[sirq_pkg::B_STACK] = call_stack_error
            && (op_mode == sirq_pkg::SIRQ_MODE_SEQ);
        ev[sirq_pkg::B_OPCODE] = illegal_opcode_fetch;
        ev[sirq_pkg::B_RT_STK] = terminal_cmd_stack_half;
        ev[sirq_pkg::B_RT_CIRC] = terminal_circ_buffer_half;
        ev[sirq_pkg::B_MT_STK] = monitor_cmd_stack_half;
        ev[sirq_pkg::B_MT_DATA] = monitor_data_stack_half;
        ev[sirq_pkg::B_SELFTEST] = self_test_done;
    end

    // register file next state
    always_comb begin
        st_d = st_q;
        // enable register write
        if (host_wr && host_addr == sirq_pkg::OFF_IRQ_EN2) begin
            st_d.en2 = host_wdata;
        end
        // sticky events, set regardless of enable
        st_d.st2 = st_q.st2 | (ev & sirq_pkg::EVENT_MASK);
        // user irq bits take the parameter's low four bits
        if (sequencer_user_irq_stb) begin
            st_d.st2[5:2] = sequencer_user_irq[3:0];
        end
        // summary bits are live
        st_d.st2[sirq_pkg::B_FIRST] = |first_status;
        st_d.st2[sirq_pkg::B_SUMMARY] =
            |(st_d.st2 & sirq_pkg::EVENT_MASK);
        // self-test bits sticky until the test is restarted
        if (self_test_clear) begin
            st_d.selftest = sirq_pkg::RST_SELFTEST;
        end
        if (prot_test_done) st_d.selftest[sirq_pkg::ST_PROT_DONE] = 1'b1;
        if (prot_test_busy) st_d.selftest[sirq_pkg::ST_PROT_BUSY] = 1'b1;
        if (prot_test_pass) st_d.selftest[sirq_pkg::ST_PROT_PASS] = 1'b1;
        if (prot_test_abort) st_d.selftest[sirq_pkg::ST_PROT_ABORT] = 1'b1;
        if (prot_test_done | prot_test_busy) begin
            st_d.selftest[sirq_pkg::ST_PROT_DONE_OR_BUSY] = 1'b1;
        end
        if (ram_test_done) begin
            st_d.selftest[sirq_pkg::ST_RAM_DONE] = 1'b1;
        end
        if (ram_test_busy) begin
            st_d.selftest[sirq_pkg::ST_RAM_BUSY] = 1'b1;
        end
        if (ram_test_pass) begin
            st_d.selftest[sirq_pkg::ST_RAM_PASS] = 1'b1;
        end
        // unused positions forced low
        st_d.selftest[10:8] = 3'b000;
        st_d.selftest[4:0] = 5'b0_0000;
        // completion level kept for the rising-edge detect
        st_d.done = prot_test_done | ram_test_done;
        // flags copied so the output comes from a register
        st_d.gflags = flags_w;
        // masked interrupt request
        st_d.irq = |(st_q.st2 & st_q.en2 & sirq_pkg::EVENT_MASK);
        // read data, registered
        st_d.rvalid = host_rd;
        st_d.rdata = 16'h0000;
        if (host_rd) begin
            case (host_addr)
                sirq_pkg::OFF_FLAG_CC: st_d.rdata = cond_code;
                sirq_pkg::OFF_SELFTEST: st_d.rdata = st_q.selftest;
                sirq_pkg::OFF_IRQ_EN2: st_d.rdata = st_q.en2;
                sirq_pkg::OFF_IRQ_ST2: st_d.rdata = st_q.st2;
                default: st_d.rdata = 16'h0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.en2 <= sirq_pkg::RST_EN2;
            st_q.st2 <= sirq_pkg::RST_ST2;
            st_q.selftest <= sirq_pkg::RST_SELFTEST;
            st_q.rdata <= 16'h0000;
            st_q.rvalid <= 1'b0;
            st_q.irq <= 1'b0;
            st_q.done <= 1'b0;
            st_q.gflags <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign general_flags = st_q.gflags;
    assign host_rdata = st_q.rdata;
    assign host_rdata_valid = st_q.rvalid;
    assign irq_req = st_q.irq;
endmodule // sirq_top

// >>> sirq_top_checker.sv
// checker: host port, flag and interrupt properties of sirq_top
module sirq_top_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic host_rdata_valid,
    input wire logic [15:0] cond_code,
    input wire logic [15:0] first_status,
    input wire logic prot_test_done,
    input wire logic self_test_clear,
    input wire logic [7:0] general_flags,
    input wire logic irq_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // decoded host cycles and flag write fields
    wire logic flag_wr = host_wr && host_addr == 5'h1b;
    wire logic test_rd = host_rd && host_addr == 5'h1c;
    wire logic stat_rd = host_rd && host_addr == 5'h1e;
    wire logic [7:0] set_b = host_wdata[7:0];
    wire logic [7:0] clr_b = host_wdata[15:8] & ~host_wdata[7:0];
    wire logic fs_any = |first_status;
    a_read_valid: assert property (host_rd |=> host_rdata_valid)
        else $error("read not answered");
    a_cc_read: assert property (
        host_rd && host_addr == 5'h1b |=> host_rdata == $past(cond_code))
        else $error("condition code read wrong");
    a_flag_set: assert property (
        flag_wr ##1 !host_wr |=> (general_flags & $past(set_b, 2))
        == $past(set_b, 2)) else $error("flag not set");
    a_flag_clear: assert property (
        flag_wr ##1 !host_wr |=> (general_flags & $past(clr_b, 2))
        == 8'h00) else $error("flag not cleared");
    a_test_zero: assert property (
        test_rd |=> host_rdata[10:8] == 3'h0 && host_rdata[4:0] == 5'h00)
        else $error("self-test spare bits set");
    a_test_sticky: assert property (
        (prot_test_done && !self_test_clear) ##1 (test_rd && !self_test_clear)
        |=> host_rdata[15]) else $error("test done not held");
    a_summary_bit: assert property (
        stat_rd ##1 (host_rdata[14:1] != 14'h0000) |-> host_rdata[15])
        else $error("summary bit missing");
    a_first_sum: assert property (
        stat_rd && $past(rst_n) && $stable(fs_any) |=> host_rdata[0]
        == $past(fs_any)) else $error("first status summary wrong");
    a_mask_all: assert property (
        (host_wr && host_addr == 5'h1d && host_wdata == 16'h0000) ##1
        !host_wr |=> !irq_req) else $error("irq with all masked");
endmodule // sirq_top_checker

// >>> sirq_top_test.sv
// self-checking bench for sirq_top
module sirq_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, host_wr, host_rd, host_rdata_valid, stb, clr, irq_req;
    logic [4:0] host_addr;
    logic [15:0] host_wdata, host_rdata, cond_code, first_status, uirq, exp;
    logic [1:0] op_mode;
    logic [9:0] ev; // event pulses, ev[i] lands in status bit i+6 for i up to 8 (i = 5, 6 in sequencer mode only), ev[9] in bit 12 in RT and MON modes
    logic [6:0] st; // self-test condition levels
    logic [7:0] general_flags;
    logic [15:0] fw[3] = '{16'h00a5, 16'h0f30, 16'h0101};
    logic [15:0] fx[3] = '{16'h00a5, 16'h00b0, 16'h00b1};
    logic [15:0] en[4] = '{16'h4000, 16'h0000, 16'h0004, 16'h0008};
    logic [3:0] ix = 4'h9; // expected irq per enable step
    int fail_count = 0;
    int n_tests = 0;
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sirq_top dut (.clk(clk), .rst_n(rst_n), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
        .cond_code(cond_code), .op_mode(op_mode),
        .sequencer_instr_parity_err(ev[8]),
        .illegal_cmd_or_msg_stored(ev[7]), .gp_queue_rollover(ev[6]),
        .isq_queue_rollover(ev[9]), .call_stack_error(ev[5]),
        .illegal_opcode_fetch(ev[4]), .terminal_cmd_stack_half(ev[3]),
        .terminal_circ_buffer_half(ev[2]), .monitor_cmd_stack_half(ev[1]),
        .monitor_data_stack_half(ev[0]), .sequencer_user_irq_stb(stb),
        .sequencer_user_irq(uirq), .first_status(first_status),
        .prot_test_done(st[6]), .prot_test_busy(st[5]),
        .prot_test_pass(st[4]), .prot_test_abort(st[3]),
        .ram_test_done(st[2]), .ram_test_busy(st[1]), .ram_test_pass(st[0]),
        .self_test_clear(clr), .general_flags(general_flags),
        .irq_req(irq_req));
    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    // verdict and end of run
    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one host write, strobe held for one edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk);
        host_wr <= 1'b0;
        @(posedge clk);
    endtask
    // one host read, answer checked mid-cycle while it stands
    task automatic rd(input logic [4:0] a, input logic [15:0] want);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk);
        host_rd <= 1'b0;
        @(negedge clk);
        check({15'h0000, host_rdata_valid}, 16'h0001);
        check(host_rdata, want);
        @(posedge clk);
    endtask
    // one-cycle event pulse
    task automatic fire(input logic [9:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 10'h000;
        @(posedge clk);
    endtask
    // reset held two cycles
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    // main sequence
    initial begin
        {host_addr, host_wdata, host_wr, host_rd, op_mode, ev, st} = '0;
        {stb, clr, uirq, first_status} = '0;
        cond_code = 16'h5a3c;
        exp = 16'h8000;
        do_reset;
        rd(5'h1b, 16'h5a3c);
        rd(5'h1c, 16'h0000);
        rd(5'h1d, 16'h0000);
        rd(5'h1e, 16'h0000);
        rd(5'h03, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wr(5'h1b, fw[k]);
            @(posedge clk);
            #1;
            check({8'h00, general_flags}, fx[k]);
        end
        rd(5'h1b, 16'h5a3c);
        wr(5'h1d, 16'h7ffe);
        rd(5'h1d, 16'h7ffe);
        wr(5'h1d, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            fire(10'h001 << i);
            exp[i + 6] = 1'b1;
            rd(5'h1e, exp);
            check({15'h0000, irq_req}, 16'h0000);
        end
        for (int k = 0; k < 2; k++) begin
            uirq <= k ? 16'h0006 : 16'hfff9;
            stb <= 1'b1;
            @(posedge clk);
            stb <= 1'b0;
            @(posedge clk);
            exp[5:2] = uirq[3:0];
            rd(5'h1e, exp);
        end
        for (int k = 0; k < 4; k++) begin
            wr(5'h1d, en[k]);
            @(posedge clk);
            #1;
            check({15'h0000, irq_req}, {15'h0000, ix[k]});
        end
        first_status <= 16'h0100;
        repeat (2) @(posedge clk);
        exp[0] = 1'b1;
        rd(5'h1e, exp);
        st <= 7'h7f;
        @(posedge clk);
        st <= 7'h00;
        rd(5'h1c, 16'hf8e0);
        exp[1] = 1'b1;
        rd(5'h1e, exp);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        rd(5'h1c, 16'h0000);
        first_status <= 16'h0000;
        do_reset;
        op_mode <= 2'h1;
        fire(10'h060);
        rd(5'h1e, 16'h0000);
        fire(10'h200);
        rd(5'h1e, 16'h9000);
        op_mode <= 2'h2;
        fire(10'h080);
        rd(5'h1e, 16'hb000);
        wrap_up;
    end
    // cut a hang short
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        wrap_up;
    end
endmodule // sirq_top_test
bind sirq_top sirq_top_checker chk (.clk(clk), .rst_n(rst_n),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid), .cond_code(cond_code),
    .first_status(first_status), .prot_test_done(prot_test_done),
    .self_test_clear(self_test_clear), .general_flags(general_flags),
    .irq_req(irq_req));
